// >>> logic/sfm_pkg.sv
// constants shared by the serial flash and trusted module pin master
package sfm_pkg;
   // ***************************************************************
   // transfer modes
   // ***************************************************************
   localparam logic [2:0] MODE_SINGLE   = 3'h0;
   localparam logic [2:0] MODE_DUAL_OUT = 3'h1;
   localparam logic [2:0] MODE_DUAL_IO  = 3'h2;
   localparam logic [2:0] MODE_QUAD_OUT = 3'h3;
   localparam logic [2:0] MODE_QUAD_IO  = 3'h4;

   // ***************************************************************
   // targets and select levels
   // ***************************************************************
   localparam logic [1:0] TGT_PRIMARY   = 2'h0;
   localparam logic [1:0] TGT_SECONDARY = 2'h1;
   localparam logic [1:0] TGT_TRUSTED   = 2'h2;
   localparam logic [2:0] SEL_NONE      = 3'h7;

   // ***************************************************************
   // serial clock rates
   // ***************************************************************
   localparam logic [1:0] RATE_20       = 2'h0;
   localparam logic [1:0] RATE_33       = 2'h1;
   localparam logic [1:0] RATE_50       = 2'h2;
   localparam int         CLK_PERIOD_PS = 10000;
   localparam int         SCK_20_PS     = 50000;
   localparam int         SCK_33_PS     = 30303;
   localparam int         SCK_50_PS     = 20000;
   // least period rounds up to whole master clocks
   localparam logic [3:0] DIV_20 =
      4'((SCK_20_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] DIV_33 =
      4'((SCK_33_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] DIV_50 =
      4'((SCK_50_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // ***************************************************************
   // lane reset values
   // ***************************************************************
   localparam logic [3:0] LANE_IDLE_OUT = 4'h0;
   localparam logic [3:0] LANE_IDLE_OE  = 4'h1;
endpackage : sfm_pkg

// >>> logic/sfm_clk_div.sv
// serial clock divider with rise and fall enable pulses
`timescale 1ns/1ps
`default_nettype none
module sfm_clk_div (
   input  wire logic       mclk_in,   // master clock
   input  wire logic       nrst_in,   // sync reset, active low
   input  wire logic       run_in,    // advance the divider
   input  wire logic [3:0] div_in,    // master clocks per period
   output logic            rise_out,  // sck goes high next edge
   output logic            fall_out,  // sck goes low next edge
   output logic            sck_out    // serial clock level
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       sck;
   } sfm_div_t;

   sfm_div_t   r_reg;
   sfm_div_t   r_next;
   logic [3:0] low_len;
   logic [3:0] high_len;

   // low half takes the odd cycle so data has more setup
   always_comb begin
      high_len = {1'b0, div_in[3:1]};
      low_len  = div_in - high_len;
      r_next   = r_reg;
      rise_out = 1'b0;
      fall_out = 1'b0;
      if (run_in) begin
         if (!r_reg.sck && r_reg.cnt == low_len - 4'h1) begin
            rise_out    = 1'b1;
            r_next.sck  = 1'b1;
            r_next.cnt  = 4'h0;
         end else if (r_reg.sck && r_reg.cnt == high_len - 4'h1) begin
            fall_out    = 1'b1;
            r_next.sck  = 1'b0;
            r_next.cnt  = 4'h0;
         end else begin
            r_next.cnt  = r_reg.cnt + 4'h1;
         end
      end
   end

   // state register
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sck_out = r_reg.sck;
endmodule : sfm_clk_div
`default_nettype wire

// >>> logic/sfm_master.sv
// pin master for two serial flashes and one trusted module
`timescale 1ns/1ps
`default_nettype none
module sfm_master (
   input  wire logic       mclk_in,       // 100 MHz master clock
   input  wire logic       nrst_in,       // sync reset, active low
   input  wire logic       start_in,      // begin a transaction
   input  wire logic [1:0] target_in,     // which select to use
   input  wire logic [2:0] mode_in,       // transfer mode
   input  wire logic [1:0] rate_in,       // serial clock rate
   input  wire logic       strap_bidir_in,// soft strap: bidir lanes 0/1
   input  wire logic [7:0] cmd_in,        // command byte
   input  wire logic [7:0] tx_count_in,   // bytes after the command
   input  wire logic [3:0] dummy_in,      // turnaround clocks
   input  wire logic [7:0] rx_count_in,   // bytes to read
   input  wire logic [7:0] tx_data_in,    // next byte to send
   input  wire logic       tx_valid_in,   // tx byte present
   output logic            tx_ready_out,  // tx byte taken this cycle
   output logic [7:0]      rx_data_out,   // received byte
   output logic            rx_valid_out,  // rx byte pulse
   output logic            busy_out,      // transaction running
   output logic            done_out,      // transaction end pulse
   output logic            refused_out,   // start refused pulse
   input  wire logic       resume_well_reset_n_in, // pin, active low
   output logic            pullup_en_out, // lane pull-ups enabled
   output logic            serial_flash_clock_out, // shared clock
   output logic            primary_flash_select_n_out,   // select 0
   output logic            secondary_flash_select_n_out, // select 1
   output logic            trusted_module_select_n_out,  // select 2
   input  wire logic [3:0] lane_in,       // lanes 3..0 pin levels
   output logic [3:0]      lane_out,      // lanes 3..0 drive values
   output logic [3:0]      lane_oe_out    // lanes 3..0 drive enables
);
   // ***************************************************************
   // state
   // ***************************************************************
   typedef enum logic [2:0] {
      PH_IDLE, PH_CMD, PH_TX, PH_DUMMY, PH_RX, PH_DONE
   } sfm_phase_t;

   typedef struct packed {
      sfm_phase_t state;
      logic [2:0] cs_n;
      logic [2:0] mode;
      logic [1:0] rate;
      logic       strap;
      logic [7:0] shreg;
      logic [2:0] clk_cnt;
      logic [7:0] tx_left;
      logic [7:0] rx_left;
      logic [3:0] dummy_cnt;
      logic       load_pend;
      logic [3:0] lane_out;
      logic [3:0] lane_oe;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic       rst_sync1;
      logic       rst_sync2;
      logic [7:0] rx_data;
      logic       rx_valid;
      logic       done;
      logic       refused;
   } sfm_state_t;

   sfm_state_t r_reg;
   sfm_state_t r_next;
   logic       rise;
   logic       fall;
   logic       sck;
   logic       run;
   logic       stall;
   logic [3:0] div;

   // ***************************************************************
   // lane helpers
   // ***************************************************************
   function automatic logic [2:0] tx_w(input logic [2:0] m);
      tx_w = (m == sfm_pkg::MODE_DUAL_IO) ? 3'h2 :
             (m == sfm_pkg::MODE_QUAD_IO) ? 3'h4 : 3'h1;
   endfunction : tx_w

   function automatic logic [2:0] rx_w(input logic [2:0] m,
                                       input logic       s);
      rx_w = (m == sfm_pkg::MODE_DUAL_IO)  ? 3'h2 :
             (m == sfm_pkg::MODE_DUAL_OUT) ? (s ? 3'h2 : 3'h1) :
             (m == sfm_pkg::MODE_SINGLE)   ? 3'h1 : 3'h4;
   endfunction : rx_w

   function automatic logic [2:0] last_idx(input logic [2:0] w);
      last_idx = (w == 3'h4) ? 3'h1 : (w == 3'h2) ? 3'h3 : 3'h7;
   endfunction : last_idx

   // lanes two and three idle high in dual io as hold/protect
   function automatic logic [3:0] drive(input logic [7:0] sh,
                                        input logic [2:0] w);
      drive = (w == 3'h4) ? sh[7:4] :
              (w == 3'h2) ? {2'b11, sh[7:6]} : {3'b110, sh[7]};
   endfunction : drive

   function automatic logic [3:0] oe_for(input logic       out_ph,
                                         input logic [2:0] w,
                                         input logic [2:0] m,
                                         input logic       s);
      logic hi;
      hi = (m == sfm_pkg::MODE_DUAL_IO);
      if (out_ph) begin
         oe_for = (w == 3'h4) ? 4'hF :
                  (w == 3'h2) ? {hi, hi, 2'b11} : {hi, hi, 2'b01};
      end else begin
         oe_for = {hi, hi, 1'b0, !s};
      end
   endfunction : oe_for

   // ***************************************************************
   // serial clock
   // ***************************************************************
   // rate held for the whole transaction
   always_comb begin
      case (r_reg.rate)
         sfm_pkg::RATE_33: div = sfm_pkg::DIV_33;
         sfm_pkg::RATE_50: div = sfm_pkg::DIV_50;
         default:          div = sfm_pkg::DIV_20;
      endcase
   end

   // clock stretched high while a tx byte is missing
   assign stall = r_reg.load_pend && r_reg.state == PH_TX
                  && !tx_valid_in;
   assign run   = r_reg.state != PH_IDLE && !stall;

   sfm_clk_div u_div (
      .mclk_in  (mclk_in),
      .nrst_in  (nrst_in),
      .run_in   (run),
      .div_in   (div),
      .rise_out (rise),
      .fall_out (fall),
      .sck_out  (sck)
   );

   // ***************************************************************
   // sequencer
   // ***************************************************************
   always_comb begin
      logic       bad;
      logic [2:0] w;
      bad            = 1'b0;
      w              = 3'h1;
      r_next         = r_reg;
      r_next.rx_valid = 1'b0;
      r_next.done    = 1'b0;
      r_next.refused = 1'b0;
      // two flops before any logic reads a pin
      r_next.sync1     = lane_in;
      r_next.sync2     = r_reg.sync1;
      r_next.rst_sync1 = resume_well_reset_n_in;
      r_next.rst_sync2 = r_reg.rst_sync1;
      case (r_reg.state)
         PH_IDLE: begin
            bad = target_in > sfm_pkg::TGT_TRUSTED
                  || mode_in > sfm_pkg::MODE_QUAD_IO
                  || rate_in > sfm_pkg::RATE_50
                  || (mode_in > sfm_pkg::MODE_DUAL_OUT
                      && !strap_bidir_in);
            if (start_in && bad) begin
               r_next.refused = 1'b1;
            end else if (start_in) begin
               r_next.cs_n = ~(3'h1 << target_in);
               r_next.mode      = mode_in;
               r_next.rate      = rate_in;
               r_next.strap     = strap_bidir_in;
               r_next.tx_left   = tx_count_in;
               r_next.rx_left   = rx_count_in;
               r_next.dummy_cnt = dummy_in;
               r_next.shreg     = cmd_in;
               r_next.clk_cnt   = 3'h0;
               r_next.lane_out  = drive(cmd_in, 3'h1);
               r_next.lane_oe   = oe_for(1'b1, 3'h1, mode_in,
                                         strap_bidir_in);
               r_next.state     = PH_CMD;
            end
         end
         PH_DONE: begin
            // select released only once the clock is low again
            if (fall) begin
               r_next.cs_n     = sfm_pkg::SEL_NONE;
               r_next.lane_out = sfm_pkg::LANE_IDLE_OUT;
               r_next.lane_oe  = sfm_pkg::LANE_IDLE_OE;
               r_next.done     = 1'b1;
               r_next.state    = PH_IDLE;
            end
         end
         default: begin
            w = (r_reg.state == PH_CMD) ? 3'h1 :
                (r_reg.state == PH_TX)  ? tx_w(r_reg.mode) :
                rx_w(r_reg.mode, r_reg.strap);
            if (rise) begin
               if (r_reg.state == PH_RX) begin
                  r_next.shreg = (w == 3'h4) ?
                     {r_reg.shreg[3:0], r_reg.sync2} :
                     (w == 3'h2) ?
                     {r_reg.shreg[5:0], r_reg.sync2[1:0]} :
                     {r_reg.shreg[6:0], r_reg.sync2[1]};
               end
               if (r_reg.state == PH_DUMMY) begin
                  r_next.dummy_cnt = r_reg.dummy_cnt - 4'h1;
                  if (r_reg.dummy_cnt == 4'h1) begin
                     r_next.state = (r_reg.rx_left != 8'h0) ?
                                    PH_RX : PH_DONE;
                  end
               end else if (r_reg.clk_cnt != last_idx(w)) begin
                  r_next.clk_cnt = r_reg.clk_cnt + 3'h1;
               end else begin
                  r_next.clk_cnt = 3'h0;
                  if (r_reg.state == PH_RX) begin
                     r_next.rx_data  = r_next.shreg;
                     r_next.rx_valid = 1'b1;
                     r_next.rx_left  = r_reg.rx_left - 8'h1;
                     if (r_reg.rx_left == 8'h1) begin
                        r_next.state = PH_DONE;
                     end
                  end else if (r_reg.tx_left != 8'h0) begin
                     r_next.state     = PH_TX;
                     r_next.load_pend = 1'b1;
                  end else if (r_reg.dummy_cnt != 4'h0) begin
                     r_next.state     = PH_DUMMY;
                     r_next.load_pend = 1'b1;
                  end else if (r_reg.rx_left != 8'h0) begin
                     r_next.state     = PH_RX;
                     r_next.load_pend = 1'b1;
                  end else begin
                     r_next.state = PH_DONE;
                  end
               end
            end else if (fall) begin
               // new data launched on the falling edge
               if (r_reg.load_pend) begin
                  r_next.load_pend = 1'b0;
                  if (r_reg.state == PH_TX) begin
                     r_next.shreg    = tx_data_in;
                     r_next.tx_left  = r_reg.tx_left - 8'h1;
                     r_next.lane_out = drive(tx_data_in, w);
                     r_next.lane_oe  = oe_for(1'b1, w, r_reg.mode,
                                              r_reg.strap);
                  end else begin
                     r_next.lane_oe = oe_for(1'b0, w, r_reg.mode,
                                             r_reg.strap);
                  end
               end else if (r_reg.state == PH_CMD
                            || r_reg.state == PH_TX) begin
                  r_next.shreg    = r_reg.shreg << w;
                  r_next.lane_out = drive(r_reg.shreg << w, w);
               end
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         r_reg          <= '0;
         r_reg.state    <= PH_IDLE;
         r_reg.cs_n     <= sfm_pkg::SEL_NONE;
         r_reg.lane_out <= sfm_pkg::LANE_IDLE_OUT;
         r_reg.lane_oe  <= sfm_pkg::LANE_IDLE_OE;
      end else begin
         r_reg <= r_next;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign tx_ready_out = fall && r_reg.load_pend
                         && r_reg.state == PH_TX;
   assign rx_data_out  = r_reg.rx_data;
   assign rx_valid_out = r_reg.rx_valid;
   assign busy_out     = r_reg.state != PH_IDLE;
   assign done_out     = r_reg.done;
   assign refused_out  = r_reg.refused;
   assign pullup_en_out = r_reg.rst_sync2;
   assign serial_flash_clock_out       = sck;
   assign primary_flash_select_n_out   = r_reg.cs_n[0];
   assign secondary_flash_select_n_out = r_reg.cs_n[1];
   assign trusted_module_select_n_out  = r_reg.cs_n[2];
   assign lane_out    = r_reg.lane_out;
   assign lane_oe_out = r_reg.lane_oe;

   // ***************************************************************
   // assertions
   // ***************************************************************
   logic [3:0] low_run;
   // length of the current low half of the serial clock
   always_ff @(posedge mclk_in) begin
      if (!nrst_in || sck) begin
         low_run <= 4'h0;
      end else if (low_run != 4'hF) begin
         low_run <= low_run + 4'h1;
      end
   end

   a_one_select: assert property (@(posedge mclk_in)
      disable iff (!nrst_in) $onehot0(~r_reg.cs_n))
      else $error("more than one select low");
   a_select_held: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      busy_out && r_reg.state != PH_DONE |=> $stable(r_reg.cs_n))
      else $error("select changed inside a transaction");
   a_select_busy: assert property (@(posedge mclk_in)
      disable iff (!nrst_in) busy_out == (r_reg.cs_n != 3'h7))
      else $error("select level disagrees with busy");
   a_clock_idle: assert property (@(posedge mclk_in)
      disable iff (!nrst_in) !busy_out |-> !sck)
      else $error("serial clock not low while idle");
   a_clock_rate: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      $rose(sck) |-> $past(low_run) >= div - {1'b0, div[3:1]} - 4'h1)
      else $error("serial clock low half too short");
   a_lane0_drive: assert property (@(posedge mclk_in)
      disable iff (!nrst_in) !r_reg.strap |-> lane_oe_out[0])
      else $error("lane zero released without strap");
   a_lane1_input: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      !r_reg.strap || r_reg.state == PH_RX |-> !lane_oe_out[1])
      else $error("lane one driven as input");
   a_upper_unused: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      r_reg.mode <= sfm_pkg::MODE_DUAL_OUT |-> lane_oe_out[3:2] == 2'b00)
      else $error("upper lanes driven in narrow mode");
   a_pullup_gate: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      !resume_well_reset_n_in ##1 !resume_well_reset_n_in
      |=> !pullup_en_out)
      else $error("pull-ups enabled during resume reset");
endmodule : sfm_master
`default_nettype wire

// >>> dv/sfm_flash_model.sv
// behavioural flash and trusted module on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module sfm_flash_model (
   input  wire logic       sck_in,   // serial clock
   input  wire logic [2:0] sel_n_in, // selects, active low
   input  wire logic [3:0] lane_in,  // resolved lane levels
   input  wire logic [7:0] pre_in,   // clocks before read data
   input  wire logic [7:0] cap_in,   // clocks taken on lane zero
   input  wire logic [2:0] width_in, // read bits per clock
   input  wire logic [7:0] resp_in,  // byte sent back each time
   output logic [3:0]      drv_out,  // lane drive values
   output logic [3:0]      oe_out,   // lane drive enables
   output logic [7:0]      got_out,  // byte taken from lane zero
   output logic            stb_out   // pulse per byte taken
);
   // ***************************************************************
   // frame tracking
   // ***************************************************************
   int         rises;
   int         k;
   logic [3:0] msk;

   // quiet lanes until a frame starts
   initial begin
      rises = 0;
      {oe_out, drv_out, got_out, stb_out} = '0;
   end

   // one model answers flash selects and the trusted module select
   always @(sel_n_in) begin
      if (&sel_n_in) begin
         rises = 0;
         oe_out = 4'h0;
      end
   end

   // master bits taken on each rise, mode 0
   always @(posedge sck_in) begin
      if (!(&sel_n_in)) begin
         rises = rises + 1;
         got_out = {got_out[6:0], lane_in[0]};
         if (rises <= cap_in && rises % 8 == 0) begin
            stb_out = 1'b1;
            #1 stb_out = 1'b0;
         end
      end
   end

   // read data launched just after a fall; a late deselect wins
   always @(negedge sck_in) begin
      if (!(&sel_n_in) && rises >= pre_in) begin
         k = (rises - pre_in) * width_in % 8;
         msk = width_in == 4 ? 4'hF : width_in == 2 ? 4'h3 : 4'h1;
         #1;
         if (!(&sel_n_in)) begin
            drv_out = 4'(resp_in >> (8 - k - width_in)) & msk;
            oe_out = msk;
            if (width_in == 1) begin
               drv_out = drv_out << 1;
               oe_out = 4'h2;
            end
         end
      end
   end
endmodule : sfm_flash_model
`default_nettype wire

// >>> dv/tb_sfm_master.sv
// self-checking bench for the serial flash pin master
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module tb_sfm_master;
   // ***************************************************************
   // signals
   // ***************************************************************
   logic       mclk_in, nrst_in, start_in, strap_in, tx_valid_in, tgl;
   logic [1:0] target_in, rate_in;
   logic [2:0] mode_in, width, sel_n, cur_sel;
   logic [3:0] dummy_in, pin, l_out, l_oe, m_drv, m_oe;
   logic [7:0] cmd_in, ntx_in, nrx_in, tx_data_in, rx_data, got;
   logic [7:0] resp, pre, cap, e_rx, e_c;
   logic       tx_ready, rx_valid, busy, refused, rwr_n, pu_en, sck;
   logic       stb, cur_strap, chk_per, done, busy_d;
   longint     exp_per, last_rise;
   int         num_errors, compares, ref_n;
   logic [7:0] rx_q[$];
   logic [7:0] cmd_q[$];

   sfm_master u_sfm_master (
      .mclk_in(mclk_in), .nrst_in(nrst_in), .start_in(start_in),
      .target_in(target_in), .mode_in(mode_in), .rate_in(rate_in),
      .strap_bidir_in(strap_in), .cmd_in(cmd_in), .tx_count_in(ntx_in),
      .dummy_in(dummy_in), .rx_count_in(nrx_in), .tx_data_in(tx_data_in),
      .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready),
      .rx_data_out(rx_data), .rx_valid_out(rx_valid), .busy_out(busy),
      .done_out(done), .refused_out(refused), .resume_well_reset_n_in(rwr_n),
      .pullup_en_out(pu_en), .serial_flash_clock_out(sck),
      .primary_flash_select_n_out(sel_n[0]),
      .secondary_flash_select_n_out(sel_n[1]),
      .trusted_module_select_n_out(sel_n[2]),
      .lane_in(pin), .lane_out(l_out), .lane_oe_out(l_oe));

   sfm_flash_model u_sfm_flash_model (
      .sck_in(sck), .sel_n_in(sel_n), .lane_in(pin), .pre_in(pre),
      .cap_in(cap), .width_in(width), .resp_in(resp), .drv_out(m_drv),
      .oe_out(m_oe), .got_out(got), .stb_out(stb));

   // 100 MHz master clock
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   // lane levels: a clash shows as unknown; a floating lane is pulled high, or keeps moving while pull-ups are off
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (l_oe[i] && m_oe[i]) pin[i] = 1'bx;
         else if (l_oe[i]) pin[i] = l_out[i];
         else if (m_oe[i]) pin[i] = m_drv[i];
         else pin[i] = pu_en ? 1'b1 : tgl;
      end
   end

   // results against the oldest note
   always @(posedge mclk_in) begin
      tgl <= ~tgl;
      busy_d <= busy;
      if (nrst_in) begin
         // end pulse stands exactly in the first idle cycle
         `CHK(done, busy_d === 1'b1 && busy === 1'b0)
         if (rx_valid === 1'b1) begin
            e_rx = rx_q.size() ? rx_q.pop_front() : 8'hXX;
            `CHK(rx_data, e_rx)
         end
         if (refused === 1'b1) begin
            `CHK(ref_n > 0, 1'b1)
            ref_n--;
         end
         if (busy === 1'b1) `CHK(sel_n, cur_sel)
         else `CHK(sel_n, 3'h7)
         if (busy === 1'b1 && !cur_strap) `CHK(l_oe, 4'h1)
      end
   end

   // serial clock period, and bytes taken by the far side
   always @(posedge sck) begin
      if (chk_per && last_rise != 0) `CHK($time - last_rise, exp_per)
      last_rise = $time;
   end
   always @(posedge stb) begin
      e_c = cmd_q.size() ? cmd_q.pop_front() : 8'hXX;
      `CHK(got, e_c)
   end

   // tx bytes with random gaps, so the serial clock gets stretched
   always @(posedge mclk_in) begin
      if (tx_ready === 1'b1) begin
         cmd_q.push_back(tx_data_in);
         tx_data_in <= 8'($urandom);
      end
      tx_valid_in <= 1'($urandom);
   end

   // one transaction; bad marks a start that must be refused
   task automatic xfer(input logic [1:0] t, input logic [2:0] m,
         input logic [1:0] r, input logic s, input logic [3:0] d,
         input int ntx, input int n, input int w, input bit bad);
      logic [7:0] c;
      int         i;
      c = 8'($urandom);
      resp = 8'($urandom);
      pre = 8'(8 * (1 + ntx) + d);
      cap = 8'(8 * (1 + ntx));
      width = 3'(w);
      cur_sel = t == 0 ? 3'h6 : t == 1 ? 3'h5 : 3'h3;
      cur_strap = s;
      chk_per = ntx == 0 && n == 0;
      exp_per = 10 * (r == 0 ? sfm_pkg::DIV_20 :
         r == 1 ? sfm_pkg::DIV_33 : sfm_pkg::DIV_50);
      last_rise = 0;
      if (bad) ref_n++;
      else cmd_q.push_back(c);
      for (i = 0; i < n && !bad; i++) rx_q.push_back(resp);
      @(posedge mclk_in);
      start_in <= 1'b1;
      {target_in, mode_in, rate_in, strap_in} <= {t, m, r, s};
      {cmd_in, ntx_in, dummy_in, nrx_in} <= {c, 8'(ntx), d, 8'(n)};
      @(posedge mclk_in);
      start_in <= 1'b0;
      for (i = 0; i < 20000 && (i < 3 || busy !== 1'b0); i++)
         @(posedge mclk_in);
      if (i == 20000) begin
         num_errors++;
         $display("unexpected at %0t: transfer hang", $time);
         final_report();
      end
   endtask : xfer

   // move the resume-well reset pin, then look at the pull-ups
   task automatic pu_step(input logic lvl, input logic exp);
      rwr_n <= lvl;
      repeat (4) @(posedge mclk_in);
      #1;
      `CHK(pu_en, exp)
   endtask : pu_step

   task automatic final_report();
      if (num_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   // main sequence
   initial begin
      {start_in, target_in, mode_in, rate_in, strap_in, cmd_in, ntx_in,
         dummy_in, nrx_in, tx_data_in, tx_valid_in, tgl} = '0;
      {nrst_in, rwr_n, chk_per, num_errors, compares, ref_n} = '0;
      {resp, pre, cap, width, cur_strap, cur_sel} = {28'h0, 3'h7};
      busy_d = 1'b0;
      void'($urandom(2));
      pu_step(1'b0, 1'b0);
      repeat (2) @(posedge mclk_in);
      nrst_in <= 1'b1;
      pu_step(1'b0, 1'b0);
      pu_step(1'b1, 1'b1);
      for (int r = 0; r < 3; r++) xfer(2'h0, 3'h0, 2'(r), 0, 0, 0, 0, 1, 0);
      for (int t = 0; t < 3; t++) xfer(2'(t), 3'h0, 2'h0, 0, 0, 0, 2, 1, 0);
      xfer(2'h1, sfm_pkg::MODE_DUAL_OUT, 2'h0, 0, 0, 0, 3, 1, 0);
      xfer(2'h0, sfm_pkg::MODE_DUAL_IO, 2'h0, 1, 4, 0, 3, 2, 0);
      xfer(2'h2, sfm_pkg::MODE_QUAD_OUT, 2'h0, 1, 8, 0, 2, 4, 0);
      xfer(2'h0, sfm_pkg::MODE_QUAD_IO, 2'h0, 1, 6, 0, 2, 4, 0);
      xfer(2'h0, sfm_pkg::MODE_SINGLE, 2'h0, 0, 0, 2, 1, 1, 0);
      xfer(2'h3, sfm_pkg::MODE_SINGLE, 2'h0, 0, 0, 0, 0, 1, 1);
      xfer(2'h0, 3'h5, 2'h0, 0, 0, 0, 0, 1, 1);
      xfer(2'h0, sfm_pkg::MODE_SINGLE, 2'h3, 0, 0, 0, 0, 1, 1);
      xfer(2'h0, sfm_pkg::MODE_DUAL_IO, 2'h0, 0, 0, 0, 0, 2, 1);
      pu_step(1'b0, 1'b0);
      pu_step(1'b1, 1'b1);
      `CHK(rx_q.size() + cmd_q.size() + ref_n, 0)
      final_report();
   end
endmodule : tb_sfm_master
`default_nettype wire
